// ---- codec_ctrl_regs.vh ----
`ifndef CODEC_CTRL_REGS_VH
`define CODEC_CTRL_REGS_VH

// register offsets (7-bit register index on the control port)
`define ADDR_TONE_CONTROL 7'h08
`define ADDR_POWERDOWN_CTRL_STATUS 7'h26
`define ADDR_EXTENDED_FEATURE_ID 7'h28
`define ADDR_EXTENDED_FEATURE_CTRL 7'h2A
`define ADDR_FRONT_RATE 7'h2C
`define ADDR_SURROUND_RATE 7'h2E
`define ADDR_LFE_RATE 7'h30
`define ADDR_ADC_RATE_A 7'h32
`define ADDR_ADC_RATE_B 7'h34
`define ADDR_SUB_CENTRE_VOLUME 7'h36
`define ADDR_SURROUND_VOLUME 7'h38

// reset values
`define RST_TONE_CONTROL 16'h0F0F
`define RST_RATE 16'hBB80
`define RST_VOLUME 16'h8080
`define RST_AMP_POWERDOWN_REQUEST 1'h1

// tone fields
`define TONE_BASS_MSB 11
`define TONE_BASS_LSB 8
`define TONE_TREBLE_MSB 3
`define TONE_TREBLE_LSB 0
`define TONE_BYPASS_CODE 4'hF

// power-down register fields
`define PD_AMP_REQ_BIT 15
`define PD_CORE_STOP_BIT 13
`define PD_LINK_HOLD_BIT 12
`define PD_LOW_FORCED 4'hE

// extended feature id: vra, dra, centre, surround, lfe; strap at bit 14
`define FEATURE_ID_FIXED 16'h01C3
`define FEATURE_ID_STRAP_BIT 14

// extended feature control fields
`define EXT_VRA_BIT 0
`define EXT_DRA_BIT 1
`define EXT_READY_MSB 9
`define EXT_READY_LSB 6
`define EXT_READY_VALUE 4'h7

// supported rates and the snapping midpoint (44100 + 48000) / 2
`define RATE_48K 16'hBB80
`define RATE_44K1 16'hAC44
`define RATE_MIDPOINT 16'hB3E2

// volume byte layout: mute above a 7-bit level
`define VOL_MUTE_BIT 7
`define VOL_FC_LEVEL_MASK 8'hBF

`endif

// ---- audio_codec_control_register_bank.v ----
// Contract
// - tone: bass bits 11-8, treble bits 3-0
// - tone code 1111 bypasses, others are gain
// - tone register resets to 0F0Fh
// - tone drives front left/right only
// - bit 12 holds link low until reset
// - bit 13 stops the core clock
// - bit 15 amp power-down request, resets 1
// - power-down reads return bits 3-0 as 1110
// - feature id is read-only, fixed features
// - feature id bit 14 shows the strap
// - ext control bit0 variable, bit1 double rate
// - ext control bits 9-6 always 0111
// - front rate snaps to 48000 or 44100
// - surround and lfe rates mirror front
// - double rate doubles the effective rate
// - rate registers reset to BB80h
// - adc rate registers fixed BB80h
// - volume bytes: mute bit over 7-bit level
// - volume levels are attenuation only
// - volume registers reset to 8080h
// - level width depends on operating mode
// - outside compliance mode zeroes volume level bit 6 in reads and outputs
`timescale 1ns/100ps
`default_nettype none
`include "codec_ctrl_regs.vh"

module audio_codec_control_register_bank (
    input wire ref_clk,
    input wire reset,
    input wire soft_reset,
    input wire [6:0] reg_addr,
    input wire reg_write,
    input wire [15:0] reg_wdata,
    input wire reg_read,
    output reg [15:0] reg_rdata,
    output reg reg_rdata_valid,
    input wire full_compliance_select,
    input wire secondary_strap_pin,
    output wire [3:0] bass_gain_field,
    output wire [3:0] treble_gain_field,
    output wire front_bass_bypass,
    output wire front_treble_bypass,
    output wire link_signal_hold_low,
    output wire core_clock_stop,
    output wire amp_powerdown_request,
    output wire variable_rate_enable,
    output wire double_rate_enable,
    output wire [16:0] effective_rate,
    output wire [7:0] subwoofer_volume,
    output wire [7:0] centre_volume,
    output wire [7:0] left_rear_volume,
    output wire [7:0] right_rear_volume
);

    wire clear = reset | soft_reset;
    wire wr = reg_write;

    reg [15:0] tone_control;
    reg amp_req;
    reg core_stop;
    reg link_hold;
    reg [1:0] ext_ctrl;
    reg [15:0] front_rate;
    reg [15:0] sub_centre_volume;
    reg [15:0] surround_volume;
    reg strap_s1;
    reg strap_s2;
    reg strap_s3;
    reg codec_identity_low;

    // nearest supported rate, higher on a tie
    wire [15:0] snapped_rate = (reg_wdata >= `RATE_MIDPOINT) ?
        `RATE_48K : `RATE_44K1;

    always @(posedge ref_clk) begin
        if (clear) begin
            tone_control <= `RST_TONE_CONTROL;
            amp_req <= `RST_AMP_POWERDOWN_REQUEST;
            core_stop <= 1'b0;
            link_hold <= 1'b0;
            ext_ctrl <= 2'h0;
            front_rate <= `RST_RATE;
            sub_centre_volume <= `RST_VOLUME;
            surround_volume <= `RST_VOLUME;
        end else if (wr) begin
            case (reg_addr)
            `ADDR_TONE_CONTROL: begin
                tone_control <= {4'h0, reg_wdata[11:8],
                    4'h0, reg_wdata[3:0]};
            end
            `ADDR_POWERDOWN_CTRL_STATUS: begin
                amp_req <= reg_wdata[`PD_AMP_REQ_BIT];
                core_stop <= reg_wdata[`PD_CORE_STOP_BIT];
                // only a reset may release the link hold
                link_hold <= link_hold |
                    reg_wdata[`PD_LINK_HOLD_BIT];
            end
            `ADDR_EXTENDED_FEATURE_CTRL: begin
                ext_ctrl <= reg_wdata[1:0];
            end
            `ADDR_FRONT_RATE: begin
                front_rate <= snapped_rate;
            end
            `ADDR_SUB_CENTRE_VOLUME: begin
                sub_centre_volume <= reg_wdata;
            end
            `ADDR_SURROUND_VOLUME: begin
                surround_volume <= reg_wdata;
            end
            default: begin
            end
            endcase
        end
    end

    // strap comes from a pin; act only once stages two and three agree
    always @(posedge ref_clk) begin
        if (reset) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_s3 <= 1'b0;
            codec_identity_low <= 1'b0;
        end else begin
            strap_s1 <= secondary_strap_pin;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (strap_s2 == strap_s3) begin
                codec_identity_low <= strap_s3;
            end
        end
    end

    // outside compliance mode reads only six level bits per byte
    wire [15:0] vol_mask = full_compliance_select ? 16'hFFFF :
        {`VOL_FC_LEVEL_MASK, `VOL_FC_LEVEL_MASK};

    wire [15:0] pd_read = {amp_req, 1'b0, core_stop, link_hold, 8'h00,
        `PD_LOW_FORCED};
    wire [15:0] id_read = `FEATURE_ID_FIXED |
        ({15'h0000, codec_identity_low} << `FEATURE_ID_STRAP_BIT);
    wire [15:0] ext_read = {6'h00, `EXT_READY_VALUE, 4'h0,
        ext_ctrl};

    reg [15:0] next_rdata;

    always @* begin
        case (reg_addr)
        `ADDR_TONE_CONTROL: next_rdata = tone_control;
        `ADDR_POWERDOWN_CTRL_STATUS: next_rdata = pd_read;
        `ADDR_EXTENDED_FEATURE_ID: next_rdata = id_read;
        `ADDR_EXTENDED_FEATURE_CTRL: next_rdata = ext_read;
        `ADDR_FRONT_RATE: next_rdata = front_rate;
        `ADDR_SURROUND_RATE: next_rdata = front_rate;
        `ADDR_LFE_RATE: next_rdata = front_rate;
        `ADDR_ADC_RATE_A: next_rdata = `RST_RATE;
        `ADDR_ADC_RATE_B: next_rdata = `RST_RATE;
        `ADDR_SUB_CENTRE_VOLUME: next_rdata = sub_centre_volume & vol_mask;
        `ADDR_SURROUND_VOLUME: next_rdata = surround_volume & vol_mask;
        default: next_rdata = 16'h0000;
        endcase
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // tone settings feed only the front pair processing
    assign bass_gain_field = tone_control[11:8];
    assign treble_gain_field = tone_control[3:0];
    assign front_bass_bypass =
        (tone_control[11:8] == `TONE_BYPASS_CODE);
    assign front_treble_bypass =
        (tone_control[3:0] == `TONE_BYPASS_CODE);
    assign link_signal_hold_low = link_hold;
    assign core_clock_stop = core_stop;
    assign amp_powerdown_request = amp_req;
    assign variable_rate_enable = ext_ctrl[`EXT_VRA_BIT];
    assign double_rate_enable = ext_ctrl[`EXT_DRA_BIT];
    assign effective_rate = double_rate_enable ?
        {front_rate, 1'b0} : {1'b0, front_rate};
    // levels are attenuation codes; no gain path exists
    wire [31:0] vol_bytes = {sub_centre_volume, surround_volume};
    wire [31:0] vol_shown;
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_vol
            assign vol_shown[8*ch+7:8*ch] = vol_bytes[8*ch+7:8*ch] &
                vol_mask[7:0];
        end
    endgenerate
    assign subwoofer_volume = vol_shown[31:24];
    assign centre_volume = vol_shown[23:16];
    assign left_rear_volume = vol_shown[15:8];
    assign right_rear_volume = vol_shown[7:0];

endmodule // audio_codec_control_register_bank
`default_nettype wire

// ---- acc_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module acc_props (
    input wire ref_clk,
    input wire reset,
    input wire soft_reset,
    input wire [6:0] reg_addr,
    input wire reg_read,
    input wire [15:0] reg_rdata,
    input wire full_compliance_select,
    input wire [3:0] bass_gain_field,
    input wire [3:0] treble_gain_field,
    input wire front_bass_bypass,
    input wire link_signal_hold_low,
    input wire [16:0] effective_rate,
    input wire [7:0] centre_volume
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_bypass_flag: assert property (
        front_bass_bypass == (bass_gain_field == 4'hF)) else $error("bypass");
    a_pd_low_bits: assert property (
        reg_read && reg_addr == 7'h26 |=> reg_rdata[3:0] == 4'hE)
        else $error("pd low bits");
    a_id_fixed: assert property (
        reg_read && reg_addr == 7'h28 |=> {reg_rdata[15], reg_rdata[13:0]}
        == 15'h01C3) else $error("feature id");
    a_ready_field: assert property (
        reg_read && reg_addr == 7'h2A |=> reg_rdata[15:6] == 10'h007)
        else $error("ready field");
    a_adc_fixed: assert property (
        reg_read && reg_addr == 7'h34 |=> reg_rdata == 16'hBB80)
        else $error("adc rate");
    a_hold_sticky: assert property (
        link_signal_hold_low && !soft_reset |=> link_signal_hold_low)
        else $error("hold released");
    a_soft_defaults: assert property (
        soft_reset |=> {bass_gain_field, treble_gain_field} == 8'hFF
        && effective_rate == 17'h0BB80) else $error("soft reset");
    a_rate_legal: assert property (effective_rate inside
        {17'h0BB80, 17'h0AC44, 17'h17700, 17'h15888}) else $error("rate");
    a_mask_level: assert property (
        !full_compliance_select && !$past(full_compliance_select)
        |-> !centre_volume[6]) else $error("level mask");
    cover property (soft_reset);
    cover property (link_signal_hold_low);
    cover property (effective_rate == 17'h15888);
endmodule // acc_props
`default_nettype wire

// ---- codec_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module codec_host_model (
    input wire logic ref_clk,
    output logic [6:0] reg_addr = 7'h00,
    output logic reg_write = 1'b0,
    output logic [15:0] reg_wdata = 16'h0000,
    output logic reg_read = 1'b0
);
    // idle bus shows inverted values so stale data never looks valid
    task automatic xfer(input logic w, input logic [6:0] a,
        input logic [15:0] d);
        @(posedge ref_clk);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule // codec_host_model
`default_nettype wire

// ---- tb_audio_codec_control_register_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_audio_codec_control_register_bank;
    logic ref_clk = 0, reset = 1, soft_reset = 0;
    logic full_compliance_select = 1, secondary_strap_pin = 0;
    wire [6:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata;
    wire reg_write, reg_read, reg_rdata_valid, front_bass_bypass;
    wire front_treble_bypass, link_signal_hold_low, core_clock_stop;
    wire amp_powerdown_request, variable_rate_enable, double_rate_enable;
    wire [3:0] bass_gain_field, treble_gain_field;
    wire [16:0] effective_rate;
    wire [7:0] subwoofer_volume, centre_volume;
    wire [7:0] left_rear_volume, right_rear_volume;
    logic [15:0] expq[$];
    int fails = 0, checked = 0;
    audio_codec_control_register_bank DUT (.*);
    codec_host_model host (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic check(input string n, input logic [16:0] s, e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        expq.push_back(e);
        host.xfer(1'b0, a, 16'h0000);
    endtask
    task automatic give_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (reg_rdata_valid === 1'b1) begin
            check("rdata", reg_rdata, expq.pop_front());
        end
    end
    initial begin
        #20us;
        fails++;
        give_verdict;
    end
    initial begin
        logic [15:0] d, r;
        logic [6:0] ra[12] = '{8, 'h26, 'h28, 'h2A, 'h2C, 'h2E, 'h30,
            'h32, 'h34, 'h36, 'h38, 'h3A};
        logic [15:0] rv[12] = '{'h0F0F, 'h800E, 'h01C3, 'h01C0, 'hBB80,
            'hBB80, 'hBB80, 'hBB80, 'hBB80, 'h8080, 'h8080, 0};
        void'($urandom(32'hF71A072A));
        repeat (5) @(posedge ref_clk);
        reset <= 0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        repeat (8) begin
            d = $urandom;
            r = d >= 16'hB3E2 ? 16'hBB80 : 16'hAC44;
            host.xfer(1, 7'h08, d);
            host.xfer(1, 7'h2C, d);
            host.xfer(1, 7'h36, d);
            host.xfer(1, 7'h2A, d);
            host.xfer(1, 7'h32, d);
            rd(7'h08, d & 16'h0F0F);
            rd(7'h2C, r);
            rd(7'h2E, r);
            rd(7'h30, r);
            rd(7'h32, 16'hBB80);
            rd(7'h36, d);
            rd(7'h2A, d & 16'h0003 | 16'h01C0);
            check("bass", bass_gain_field, d[11:8]);
            check("bypass", front_treble_bypass, &d[3:0]);
            check("rate", effective_rate, d[1] ? {r, 1'b0} : r);
            check("treble", treble_gain_field, d[3:0]);
            check("bass bypass", front_bass_bypass, &d[11:8]);
            check("vra", variable_rate_enable, d[0]);
            check("sub", subwoofer_volume, d[15:8]);
            check("centre", centre_volume, d[7:0]);
        end
        host.xfer(1, 7'h26, 16'hFFFF);
        rd(7'h26, 16'hB00E);
        check("hold", link_signal_hold_low, 1);
        check("stop", core_clock_stop, 1);
        check("amp", amp_powerdown_request, 1);
        host.xfer(1, 7'h26, 16'h0000);
        rd(7'h26, 16'h100E);
        check("amp clear", amp_powerdown_request, 0);
        check("hold kept", link_signal_hold_low, 1);
        full_compliance_select <= 0;
        secondary_strap_pin <= 1;
        host.xfer(1, 7'h28, 16'hFFFF);
        host.xfer(1, 7'h38, 16'hFFFF);
        rd(7'h38, 16'hBFBF);
        rd(7'h28, 16'h41C3);
        check("left rear", left_rear_volume, 8'hBF);
        check("right rear", right_rear_volume, 8'hBF);
        soft_reset <= 1;
        @(posedge ref_clk);
        soft_reset <= 0;
        rd(7'h26, 16'h800E);
        rd(7'h38, 16'h8080);
        check("hold released", link_signal_hold_low, 0);
        check("dra reset", double_rate_enable, 0);
        check("rate reset", effective_rate, 17'h0BB80);
        repeat (3) @(posedge ref_clk);
        give_verdict;
    end
endmodule // tb_audio_codec_control_register_bank
bind audio_codec_control_register_bank acc_props props (.*);
`default_nettype wire
